// ### inc/fdm_defines.vh
// Constants for the fault diagnostic monitor: timing, codes, reset values.
// Assumes a single 40 MHz system clock; included by the monitor design file.
`ifndef FDM_DEFINES_VH
`define FDM_DEFINES_VH

// System clock rate
`define FDM_CLK_MHZ          40
`define FDM_CLK_KHZ          40000

// Overcurrent blanking: (sel + 1) microseconds
`define FDM_BLANK_UNIT_US    1
`define FDM_BLANK_UNIT_CYC   (`FDM_BLANK_UNIT_US * `FDM_CLK_MHZ)
`define FDM_BLANK_W          8

// Open-load lockout: (sel + 1) * 10 ms
`define FDM_OLW_UNIT_MS      10
`define FDM_OLW_UNIT_CYC     (`FDM_OLW_UNIT_MS * `FDM_CLK_KHZ)
`define FDM_OLW_W            21

// Open-load current thresholds in mA
`define FDM_OL_THR_LO_MA     13
`define FDM_OL_THR_HI_MA     26

// Fault pin source selection codes
`define FDM_PIN_GENERAL      3'h0
`define FDM_PIN_SUPPLY       3'h1
`define FDM_PIN_OPENLOAD     3'h2

// Reset values of the sticky flags
`define FDM_PWRUP_FLAG_RST   1'b1
`define FDM_FAULT_FLAG_RST   1'b0

// Number of bridge phases
`define FDM_PHASES           2

`endif

// ### verilog/fdm_timer.v
// Reloadable down-counter used for blanking and lockout delays.
// Assumes restart_i and run_i are synchronous to clock_i.
module fdm_timer #(
  parameter W = 8
) (
  input  wire         clock_i,
  input  wire         resetn_i,
  input  wire         restart_i,
  input  wire         run_i,
  input  wire [W-1:0] load_i,
  output wire         expired_o
);
  reg [W-1:0] count_reg;
  reg         done_reg;

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_reg <= {W{1'b0}};
      done_reg  <= 1'b0;
    end else if (restart_i) begin
      count_reg <= load_i;
      done_reg  <= 1'b0;
    end else if (run_i && !done_reg) begin
      if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
        count_reg <= {W{1'b0}};
        done_reg  <= 1'b1;
      end else begin
        count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign expired_o = done_reg;

endmodule

// ### verilog/fdm_monitor.v
// Fault supervision: supply and temperature events, overcurrent
// blanking and retry, open-load checking, fault indicator pin.
// Assumes all inputs synchronous to clock_i; resetn_i is power-on reset.
`include "fdm_defines.vh"

// Overview of operation
// [RL1] Main supply overvoltage disables outputs, pulls fault low, sets supply-high flag.
// [RL2] Overvoltage gone: outputs and fault pin recover; supply-high flag stays set.
// [RL3] Main undervoltage disables outputs, pulls fault low, sets supply-low; keeps registers.
// [RL4] Undervoltage gone and no other fault: outputs and pin recover; flag stays.
// [RL5] Pump undervoltage disables outputs, pulls fault low, sets supply-low flag.
// [RL6] Logic supply loss fully disables, pin low; reset sets both power-up flags.
// [RL7] Supply fault pulls pin low when general or supply source is selected.
// [RL8] Hot warning sets its sticky flag and pulls pin low with general source; outputs stay on.
// [RL9] Overheat sets its flag and disables outputs until it clears.
// [RL10] Temperature fault pulls pin low when general source is selected.
// [RL11] Overcurrent ignored for selectable 1 to 4 us blanking, then latched.
// [RL12] Overcurrent vanishing before blanking expiry resets timer, records nothing.
// [RL13] Latched overcurrent disables that phase until a register reset or diagnostic read.
// [RL14] Retry bit 0: steps reset overcurrent states and re-enable outputs.
// [RL15] Maximum on-time latches the overcurrent state at once, without blanking.
// [RL16] Retry bit 1: steps do not reset overcurrent states.
// [RL17] Open load flagged when phase current below 13 or 26 mA threshold.
// [RL18] Open-load check only after 10 to 40 ms lockout restarted each step.
// [RL19] Phase checked only when its target exceeds twice the threshold.
// [RL20] Open load never disables the bridge; indication only.
// [RL21] Open-load states clear on steps, sequence start, PWM threshold, good check.
// [RL22] Step pin edge during open load clears fault and still steps.
// [RL23] After power-up the pin shows the general fault flag, active low.
// [RL24] Status and diagnostic flags are sticky until a register reset or an uninhibited read.
// [RL25] Status read without inhibit clears latched non-overcurrent states.
// [RL26] Blanking and lockout are system-clock counters reloaded from their fields.
module fdm_monitor #(
  parameter                   TGT_W    = 8,
  parameter [`FDM_OLW_W-1:0]  OLW_UNIT = `FDM_OLW_UNIT_CYC
) (
  input  wire                     clock_i,
  input  wire                     resetn_i,
  // Supply and temperature comparators
  input  wire                     main_supply_high_i,
  input  wire                     main_supply_low_i,
  input  wire                     pump_supply_low_i,
  input  wire                     logic_supply_low_i,
  input  wire                     hot_warn_i,
  input  wire                     overheat_i,
  // Per-phase bridge monitors, bit 0 phase A, bit 1 phase B
  input  wire [1:0]               overcurrent_i,
  input  wire [1:0]               ontime_max_i,
  input  wire [1:0]               openload_cmp_i,
  input  wire [1:0]               pwm_reached_i,
  input  wire [TGT_W-1:0]         target_a_i,
  input  wire [TGT_W-1:0]         target_b_i,
  // Step and host events
  input  wire                     step_pin_i,
  input  wire                     single_step_wr_i,
  input  wire                     seq_start_wr_i,
  input  wire                     seq_step_i,
  input  wire                     status_read_i,
  input  wire                     diagnostic_read_i,
  input  wire                     reg_reset_i,
  input  wire                     inhibit_clear_i,
  // Configuration
  input  wire [1:0]               overcurrent_blank_sel_i,
  input  wire                     overcurrent_retry_ctrl_i,
  input  wire                     openload_level_sel_i,
  input  wire [1:0]               openload_wait_sel_i,
  input  wire [2:0]               fault_pin_sel_i,
  // Results
  output wire [1:0]               bridge_en_o,
  output wire                     step_advance_o,
  output wire                     fault_indicator_pin_o,
  output wire                     fault_indicator_pin_oe_o,
  output wire                     supply_high_flag_o,
  output wire                     supply_low_flag_o,
  output wire                     power_on_flag_o,
  output wire                     power_up_fault_flag_o,
  output wire                     hot_warning_flag_o,
  output wire                     overheat_flag_o,
  output wire [1:0]               overcurrent_flag_o,
  output wire [1:0]               openload_flag_o,
  output wire [1:0]               openload_state_o
);

  localparam [`FDM_BLANK_W-1:0] BLANK_UNIT = `FDM_BLANK_UNIT_CYC;
  localparam [TGT_W:0]          THR2_LO    = 2 * `FDM_OL_THR_LO_MA;
  localparam [TGT_W:0]          THR2_HI    = 2 * `FDM_OL_THR_HI_MA;

  reg        step_prev_reg;
  reg        step_adv_reg;
  reg        pin_low_reg;
  reg        sup_high_flag_reg;
  reg        sup_low_flag_reg;
  reg        por_flag_reg;
  reg        pwr_fault_flag_reg;
  reg        hot_flag_reg;
  reg        heat_flag_reg;
  reg [1:0]  oc_state_reg;
  reg [1:0]  oc_flag_reg;
  reg [1:0]  ol_state_reg;
  reg [1:0]  ol_flag_reg;
  reg        pin_low_next;

  wire       step_rise;
  wire       any_step;
  wire       ol_restart;
  wire       ol_expired;
  wire       status_clr;
  wire       diagnostic_clr;
  wire       supply_fault;
  wire       static_off;
  wire       general_fault;
  wire [1:0] blank_exp;
  wire [1:0] oc_set;
  wire [1:0] ol_check;
  wire [1:0] ol_set;
  wire [1:0] ol_clr;
  wire [TGT_W:0] thr2;
  wire [`FDM_BLANK_W-1:0] blank_load;
  wire [`FDM_OLW_W-1:0]   olw_load;

  // Host read clears are honoured only while not inhibited
  assign status_clr = status_read_i && !inhibit_clear_i;  // [RL25]
  assign diagnostic_clr = diagnostic_read_i && !inhibit_clear_i;

  assign step_rise  = step_pin_i && !step_prev_reg;
  assign any_step   = step_rise || (single_step_wr_i && !inhibit_clear_i) || seq_step_i;
  assign ol_restart = any_step || (seq_start_wr_i && !inhibit_clear_i);  // [RL18]

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step_prev_reg <= 1'b0;
      step_adv_reg  <= 1'b0;
    end else begin
      step_prev_reg <= step_pin_i;
      // Step edge always advances, even while an open load is flagged
      step_adv_reg  <= step_rise;  // [RL22]
    end
  end
  assign step_advance_o = step_adv_reg;

  // Static disable causes; undervoltage sets its flag and leaves all other stored state untouched
  assign supply_fault = main_supply_high_i || main_supply_low_i
                      || pump_supply_low_i;  // [RL1] [RL3] [RL5]
  assign static_off   = supply_fault || overheat_i || logic_supply_low_i;  // [RL9] [RL6]

  // Reload values: (sel + 1) units each
  assign blank_load = BLANK_UNIT * ({{(`FDM_BLANK_W-2){1'b0}}, overcurrent_blank_sel_i}
                      + {{(`FDM_BLANK_W-1){1'b0}}, 1'b1});  // [RL26]
  assign olw_load   = OLW_UNIT * ({{(`FDM_OLW_W-2){1'b0}}, openload_wait_sel_i}
                      + {{(`FDM_OLW_W-1){1'b0}}, 1'b1});  // [RL26]

  // Shared open-load lockout restarted by every step
  fdm_timer #(
    .W         (`FDM_OLW_W)
  ) u_olw_timer (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .restart_i (ol_restart),
    .run_i     (1'b1),
    .load_i    (olw_load),
    .expired_o (ol_expired)
  );  // [RL18]

  assign thr2 = openload_level_sel_i ? THR2_HI : THR2_LO;  // [RL17]

  genvar p;
  generate
    for (p = 0; p < `FDM_PHASES; p = p + 1) begin : g_phase
      wire [TGT_W-1:0] target = (p == 0) ? target_a_i : target_b_i;

      // Timer held in reload while no overcurrent, so a short glitch
      // never accumulates towards a fault
      fdm_timer #(
        .W         (`FDM_BLANK_W)
      ) u_blank (
        .clock_i   (clock_i),
        .resetn_i  (resetn_i),
        .restart_i (!overcurrent_i[p]),
        .run_i     (overcurrent_i[p]),
        .load_i    (blank_load),
        .expired_o (blank_exp[p])
      );  // [RL11] [RL12]

      assign oc_set[p] = (blank_exp[p] && overcurrent_i[p])
                       || ontime_max_i[p];  // [RL11] [RL15]

      // A restarting lockout masks the check, else a step could not clear
      assign ol_check[p] = ol_expired && !ol_restart && ({1'b0, target} > thr2);  // [RL19]
      assign ol_set[p]   = ol_check[p] && openload_cmp_i[p];       // [RL17]
      assign ol_clr[p]   = ol_restart || pwm_reached_i[p]
                         || (ol_check[p] && !openload_cmp_i[p])
                         || status_clr || reg_reset_i;             // [RL21] [RL25]

      always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          oc_state_reg[p] <= 1'b0;
          oc_flag_reg[p]  <= `FDM_FAULT_FLAG_RST;
          ol_state_reg[p] <= 1'b0;
          ol_flag_reg[p]  <= `FDM_FAULT_FLAG_RST;
        end else begin
          // Set wins over every clear
          if (oc_set[p])
            oc_state_reg[p] <= 1'b1;  // [RL13]
          else if (reg_reset_i || diagnostic_clr)
            oc_state_reg[p] <= 1'b0;
          else if (any_step && !overcurrent_retry_ctrl_i)
            oc_state_reg[p] <= 1'b0;  // [RL14] [RL16]

          if (oc_set[p])
            oc_flag_reg[p] <= 1'b1;   // [RL24]
          else if (reg_reset_i || diagnostic_clr)
            oc_flag_reg[p] <= 1'b0;

          if (ol_set[p])
            ol_state_reg[p] <= 1'b1;
          else if (ol_clr[p])
            ol_state_reg[p] <= 1'b0;  // [RL21] [RL22]

          if (ol_set[p])
            ol_flag_reg[p] <= 1'b1;   // [RL24]
          else if (reg_reset_i || status_clr)
            ol_flag_reg[p] <= 1'b0;
        end
      end

      // Open load has no say in the bridge enable
      assign bridge_en_o[p] = !static_off && !oc_state_reg[p];  // [RL13] [RL20] [RL2] [RL4]
    end
  endgenerate

  // Sticky status flags: a present fault keeps its flag set through a clear
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sup_high_flag_reg  <= `FDM_FAULT_FLAG_RST;
      sup_low_flag_reg   <= `FDM_FAULT_FLAG_RST;
      por_flag_reg       <= `FDM_PWRUP_FLAG_RST;  // [RL6]
      pwr_fault_flag_reg <= `FDM_PWRUP_FLAG_RST;  // [RL6]
      hot_flag_reg       <= `FDM_FAULT_FLAG_RST;
      heat_flag_reg      <= `FDM_FAULT_FLAG_RST;
    end else begin
      if (main_supply_high_i)
        sup_high_flag_reg <= 1'b1;  // [RL1] [RL2]
      else if (status_clr || reg_reset_i)
        sup_high_flag_reg <= 1'b0;

      if (main_supply_low_i || pump_supply_low_i)
        sup_low_flag_reg <= 1'b1;   // [RL3] [RL5]
      else if (status_clr || reg_reset_i)
        sup_low_flag_reg <= 1'b0;   // [RL4]

      if (logic_supply_low_i) begin
        por_flag_reg       <= 1'b1;
        pwr_fault_flag_reg <= 1'b1;
      end else if (status_clr || reg_reset_i) begin
        por_flag_reg       <= 1'b0;
        pwr_fault_flag_reg <= 1'b0;
      end

      if (hot_warn_i)
        hot_flag_reg <= 1'b1;       // [RL8]
      else if (status_clr || reg_reset_i)
        hot_flag_reg <= 1'b0;

      if (overheat_i)
        heat_flag_reg <= 1'b1;      // [RL9]
      else if (status_clr || reg_reset_i)
        heat_flag_reg <= 1'b0;
    end
  end  // [RL24]

  // General fault: any static fault other than logic supply loss present, or any dynamic fault latched
  assign general_fault = supply_fault || hot_warn_i || overheat_i
                       || (|oc_state_reg) || (|ol_state_reg);  // [RL10] [RL23]

  always @* begin
    pin_low_next = 1'b0;
    case (fault_pin_sel_i)
      `FDM_PIN_GENERAL:  pin_low_next = general_fault;   // [RL7] [RL10] [RL23]
      `FDM_PIN_SUPPLY:   pin_low_next = supply_fault;    // [RL7]
      `FDM_PIN_OPENLOAD: pin_low_next = |ol_state_reg;
      default:           pin_low_next = 1'b0;
    endcase
    // Collapsing logic supply holds the pin low whatever is selected
    if (logic_supply_low_i)
      pin_low_next = 1'b1;  // [RL6]
  end

  // Reset value pulls low: the device is not yet up
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      pin_low_reg <= 1'b1;
    else
      pin_low_reg <= pin_low_next;
  end

  // Open drain: only ever drives low
  assign fault_indicator_pin_o    = 1'b0;
  assign fault_indicator_pin_oe_o = pin_low_reg;

  assign supply_high_flag_o    = sup_high_flag_reg;
  assign supply_low_flag_o     = sup_low_flag_reg;
  assign power_on_flag_o       = por_flag_reg;
  assign power_up_fault_flag_o = pwr_fault_flag_reg;
  assign hot_warning_flag_o    = hot_flag_reg;
  assign overheat_flag_o       = heat_flag_reg;
  assign overcurrent_flag_o    = oc_flag_reg;
  assign openload_flag_o       = ol_flag_reg;
  assign openload_state_o      = ol_state_reg;

endmodule

// ### bench/fdm_monitor_asserts.sv
// Port checker for fdm_monitor, bound from the bench top.
// Assumes one clock domain and an asynchronous active-low reset.
module fdm_monitor_asserts (
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       main_supply_high_i,
  input wire logic       main_supply_low_i,
  input wire logic       pump_supply_low_i,
  input wire logic       logic_supply_low_i,
  input wire logic       overheat_i,
  input wire logic [1:0] overcurrent_i,
  input wire logic [1:0] ontime_max_i,
  input wire logic [1:0] overcurrent_blank_sel_i,
  input wire logic       status_read_i,
  input wire logic       reg_reset_i,
  input wire logic       inhibit_clear_i,
  input wire logic [2:0] fault_pin_sel_i,
  input wire logic [1:0] bridge_en_o,
  input wire logic       fault_indicator_pin_oe_o,
  input wire logic       supply_high_flag_o,
  input wire logic       supply_low_flag_o,
  input wire logic       hot_warning_flag_o,
  input wire logic [1:0] overcurrent_flag_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] oc_run_reg;
  int         blank_n;
  wire        clr_ok = (status_read_i & ~inhibit_clear_i) | reg_reset_i;
  wire        sup_bad = main_supply_high_i | main_supply_low_i | pump_supply_low_i;
  assign blank_n = (int'(overcurrent_blank_sel_i) + 1) * 40;
  // Consecutive high cycles of phase A overcurrent, saturating
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) oc_run_reg <= 10'h000;
    else if (!overcurrent_i[0]) oc_run_reg <= 10'h000;
    else if (oc_run_reg != 10'h3FF) oc_run_reg <= oc_run_reg + 10'h001;
  end
  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  property p_high_off;
    main_supply_high_i |-> bridge_en_o == 2'b00 ##1 supply_high_flag_o;
  endproperty
  a_high_off: assert property (p_high_off) else $error("overvoltage not handled");
  property p_low_off;
    main_supply_low_i || pump_supply_low_i |-> bridge_en_o == 2'b00 ##1 supply_low_flag_o;
  endproperty
  a_low_off: assert property (p_low_off) else $error("undervoltage not handled");
  property p_heat_off;
    overheat_i |-> bridge_en_o == 2'b00;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("outputs on while overheated");
  property p_pin_sup;
    (sup_bad || logic_supply_low_i) && fault_pin_sel_i <= 3'h1 |=> fault_indicator_pin_oe_o;
  endproperty
  a_pin_sup: assert property (p_pin_sup) else $error("pin released in supply fault");
  property p_pin_temp;
    overheat_i && fault_pin_sel_i == 3'h0 |=> fault_indicator_pin_oe_o;
  endproperty
  a_pin_temp: assert property (p_pin_temp) else $error("pin released when hot");
  property p_hot_sticky;
    $fell(hot_warning_flag_o) |-> $past(clr_ok);
  endproperty
  a_hot_sticky: assert property (p_hot_sticky) else $error("hot flag lost");
  property p_ovf_sticky;
    $fell(supply_high_flag_o) |-> $past(clr_ok);
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("supply-high flag lost");
  property p_blank;
    $rose(overcurrent_flag_o[0]) |-> $past(oc_run_reg, 2) >= blank_n - 1
      || $past(ontime_max_i[0]) || $past(ontime_max_i[0], 2);
  endproperty
  a_blank: assert property (p_blank) else $error("overcurrent latched early");
  c_oc: cover property ($rose(overcurrent_flag_o[0]));
  c_low: cover property ($rose(supply_low_flag_o));
  c_high: cover property ($fell(supply_high_flag_o));
endmodule

// ### bench/fdm_host_model.sv
// Host controller model: step, write, read and reset events as one-cycle pulses.
// Assumes the bench calls cmd() hierarchically; events change just after a rising edge.
module fdm_host_model (
  input  wire logic clock_i,
  output wire logic step_pin_o,
  output wire logic single_step_wr_o,
  output wire logic seq_start_wr_o,
  output wire logic seq_step_o,
  output wire logic status_read_o,
  output wire logic diagnostic_read_o,
  output wire logic reg_reset_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] ev_reg = 7'h00;
  assign {reg_reset_o, diagnostic_read_o, status_read_o, seq_step_o} = ev_reg[6:3];
  assign {seq_start_wr_o, single_step_wr_o, step_pin_o} = ev_reg[2:0];
  // Idle cycle after each event so the step pin shows a fresh rising edge
  task automatic cmd(input logic [6:0] m);
    @(posedge clock_i) ev_reg <= m;
    @(posedge clock_i) ev_reg <= 7'h00;
  endtask
endmodule

// ### bench/fdm_monitor_tb_top.sv
// Bench top for fdm_monitor: scenario tasks, host model and checker bind.
// Assumes 40 MHz clock and a shortened open-load lockout unit.
module fdm_monitor_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [20:0] OLW = 21'h000014;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic [5:0] sup = 6'h00;
  logic [1:0] overcurrent_i = 2'h0, ontime_max_i = 2'h0, openload_cmp_i = 2'h0;
  logic [1:0] pwm_reached_i = 2'h0, overcurrent_blank_sel_i = 2'h3, openload_wait_sel_i = 2'h1;
  logic [7:0] target_a_i = 8'h1E, target_b_i = 8'h14;
  logic [2:0] fault_pin_sel_i = 3'h0;
  logic       overcurrent_retry_ctrl_i = 1'b0, openload_level_sel_i = 1'b0, inhibit_clear_i = 1'b0;
  wire main_supply_high_i = sup[0], main_supply_low_i = sup[1], pump_supply_low_i = sup[2];
  wire overheat_i = sup[3], hot_warn_i = sup[4], logic_supply_low_i = sup[5];
  wire step_pin_i, single_step_wr_i, seq_start_wr_i, seq_step_i, status_read_i, diagnostic_read_i;
  wire reg_reset_i, step_advance_o, fault_indicator_pin_o, fault_indicator_pin_oe_o;
  wire supply_high_flag_o, supply_low_flag_o, power_on_flag_o, power_up_fault_flag_o;
  wire hot_warning_flag_o, overheat_flag_o;
  wire [1:0] bridge_en_o, overcurrent_flag_o, openload_flag_o, openload_state_o;
  wire [4:0] flg = {hot_warning_flag_o, overheat_flag_o, supply_low_flag_o,
                    supply_low_flag_o, supply_high_flag_o};
  int miscompares = 0, n_tests = 0, adv = 0, n;
  fdm_monitor #(.OLW_UNIT(OLW)) fdm_monitor_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .main_supply_high_i(main_supply_high_i),
    .main_supply_low_i(main_supply_low_i), .pump_supply_low_i(pump_supply_low_i),
    .logic_supply_low_i(logic_supply_low_i), .hot_warn_i(hot_warn_i),
    .overheat_i(overheat_i), .overcurrent_i(overcurrent_i), .ontime_max_i(ontime_max_i),
    .openload_cmp_i(openload_cmp_i), .pwm_reached_i(pwm_reached_i),
    .target_a_i(target_a_i), .target_b_i(target_b_i), .step_pin_i(step_pin_i),
    .single_step_wr_i(single_step_wr_i), .seq_start_wr_i(seq_start_wr_i),
    .seq_step_i(seq_step_i), .status_read_i(status_read_i),
    .diagnostic_read_i(diagnostic_read_i), .reg_reset_i(reg_reset_i),
    .inhibit_clear_i(inhibit_clear_i), .overcurrent_blank_sel_i(overcurrent_blank_sel_i),
    .overcurrent_retry_ctrl_i(overcurrent_retry_ctrl_i),
    .openload_level_sel_i(openload_level_sel_i), .openload_wait_sel_i(openload_wait_sel_i),
    .fault_pin_sel_i(fault_pin_sel_i), .bridge_en_o(bridge_en_o),
    .step_advance_o(step_advance_o), .fault_indicator_pin_o(fault_indicator_pin_o),
    .fault_indicator_pin_oe_o(fault_indicator_pin_oe_o),
    .supply_high_flag_o(supply_high_flag_o), .supply_low_flag_o(supply_low_flag_o),
    .power_on_flag_o(power_on_flag_o), .power_up_fault_flag_o(power_up_fault_flag_o),
    .hot_warning_flag_o(hot_warning_flag_o), .overheat_flag_o(overheat_flag_o),
    .overcurrent_flag_o(overcurrent_flag_o), .openload_flag_o(openload_flag_o),
    .openload_state_o(openload_state_o));
  fdm_host_model fdm_host_model_inst (.clock_i(clock_i), .step_pin_o(step_pin_i),
    .single_step_wr_o(single_step_wr_i), .seq_start_wr_o(seq_start_wr_i),
    .seq_step_o(seq_step_i), .status_read_o(status_read_i),
    .diagnostic_read_o(diagnostic_read_i), .reg_reset_o(reg_reset_i));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (step_advance_o === 1'b1) adv <= adv + 1;
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input int c);
    repeat (c) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic h(input logic [6:0] m);
    fdm_host_model_inst.cmd(m);
  endtask
  // Bounded wait for phase A open-load state
  task automatic wait_ol();
    n = 0;
    while (openload_state_o[0] !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic t_supply(input int k);
    @(posedge clock_i) sup <= 6'h01 << k;
    w(3);
    chk("bridge_on_fault", (k == 4) ? 8'h03 : 8'h00, bridge_en_o);
    chk("pin_on_fault", 8'h01, fault_indicator_pin_oe_o);
    chk("flag_set", 8'h01, flg[k]);
    @(posedge clock_i) sup <= 6'h00;
    w(3);
    chk("bridge_back", 8'h03, bridge_en_o);
    chk("pin_back", 8'h00, fault_indicator_pin_oe_o);
    chk("flag_kept", 8'h01, flg[k]);
    h(7'h10);
    w(1);
    chk("flag_read_clr", 8'h00, flg[k]);
  endtask
  task automatic t_pin_logic();
    @(posedge clock_i) begin
      fault_pin_sel_i <= 3'h2;
      sup <= 6'h02;
    end
    w(2);
    chk("pin_ol_sel", 8'h00, fault_indicator_pin_oe_o);
    @(posedge clock_i) fault_pin_sel_i <= 3'h1;
    w(2);
    chk("pin_sup_sel", 8'h01, fault_indicator_pin_oe_o);
    chk("pin_data", 8'h00, fault_indicator_pin_o);
    @(posedge clock_i) begin
      fault_pin_sel_i <= 3'h0;
      sup <= 6'h20;
    end
    w(2);
    chk("bridge_logic", 8'h00, bridge_en_o);
    chk("pin_logic", 8'h01, fault_indicator_pin_oe_o);
    chk("pwrup_flag", 8'h01, power_up_fault_flag_o);
    @(posedge clock_i) sup <= 6'h00;
    h(7'h10);
  endtask
  task automatic t_oc();
    @(posedge clock_i) overcurrent_i <= 2'b01;
    w(149);
    @(posedge clock_i) overcurrent_i <= 2'b00;
    w(2);
    chk("oc_short", 8'h00, overcurrent_flag_o);
    @(posedge clock_i) overcurrent_i <= 2'b01;
    n = 0;
    while (overcurrent_flag_o[0] !== 1'b1 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    chk("oc_blank", 8'h01, {7'h00, n >= 160 && n <= 165});
    chk("oc_bridge", 8'h02, bridge_en_o);
    @(posedge clock_i) overcurrent_i <= 2'b00;
    w(3);
    chk("oc_held", 8'h02, bridge_en_o);
    h(7'h02);
    w(2);
    chk("oc_retry", 8'h03, bridge_en_o);
    chk("oc_pin", 8'h00, fault_indicator_pin_oe_o);
    chk("oc_flag", 8'h01, overcurrent_flag_o);
    @(posedge clock_i) begin
      overcurrent_retry_ctrl_i <= 1'b1;
      ontime_max_i <= 2'b10;
    end
    @(posedge clock_i) ontime_max_i <= 2'b00;
    w(2);
    chk("ontime", 8'h01, bridge_en_o);
    h(7'h01);
    w(3);
    chk("no_retry", 8'h01, bridge_en_o);
    @(posedge clock_i) inhibit_clear_i <= 1'b1;
    h(7'h20);
    w(1);
    chk("read_inhibit", 8'h01, bridge_en_o);
    @(posedge clock_i) inhibit_clear_i <= 1'b0;
    h(7'h40);
    w(2);
    chk("reg_reset", 8'h03, bridge_en_o);
  endtask
  task automatic t_openload();
    int a0;
    fork
      h(7'h01);
      begin
        @(posedge clock_i);
        @(posedge clock_i) openload_cmp_i <= 2'b11;
      end
    join
    wait_ol();
    chk("lockout", 8'h01, {7'h00, n >= 38 && n <= 46});
    chk("ol_phase_b", 8'h00, {7'h00, openload_state_o[1]});
    chk("ol_bridge", 8'h03, bridge_en_o);
    w(1);
    chk("ol_pin", 8'h01, fault_indicator_pin_oe_o);
    a0 = adv;
    h(7'h01);
    w(2);
    chk("ol_step_clr", 8'h00, openload_state_o);
    chk("step_count", 8'h01, 8'(adv - a0));
    wait_ol();
    @(posedge clock_i) begin
      pwm_reached_i <= 2'b01;
      target_a_i <= 8'h10;
    end
    @(posedge clock_i) pwm_reached_i <= 2'b00;
    w(1);
    chk("ol_pwm_clr", 8'h00, openload_state_o);
    chk("ol_flag", 8'h01, openload_flag_o);
    @(posedge clock_i) target_a_i <= 8'h1E;
    wait_ol();
    h(7'h04);
    w(2);
    chk("ol_seq_clr", 8'h00, openload_state_o);
    @(posedge clock_i) openload_level_sel_i <= 1'b1;
    h(7'h08);
    w(50);
    chk("ol_level_hi", 8'h00, openload_state_o);
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    chk("power_on", 8'h01, power_on_flag_o);
    chk("pwrup_fault", 8'h01, power_up_fault_flag_o);
    chk("supply_high", 8'h00, supply_high_flag_o);
    h(7'h10);
    for (int k = 0; k < 5; k++) t_supply(k);
    t_pin_logic();
    t_oc();
    t_openload();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clock_i);
    miscompares++;
    finish_test();
  end
endmodule
bind fdm_monitor fdm_monitor_asserts fdm_monitor_asserts_inst (
  .clock_i(clock_i), .resetn_i(resetn_i), .main_supply_high_i(main_supply_high_i),
  .main_supply_low_i(main_supply_low_i), .pump_supply_low_i(pump_supply_low_i),
  .logic_supply_low_i(logic_supply_low_i), .overheat_i(overheat_i),
  .overcurrent_i(overcurrent_i), .ontime_max_i(ontime_max_i),
  .overcurrent_blank_sel_i(overcurrent_blank_sel_i), .status_read_i(status_read_i),
  .reg_reset_i(reg_reset_i), .inhibit_clear_i(inhibit_clear_i),
  .fault_pin_sel_i(fault_pin_sel_i), .bridge_en_o(bridge_en_o),
  .fault_indicator_pin_oe_o(fault_indicator_pin_oe_o),
  .supply_high_flag_o(supply_high_flag_o), .supply_low_flag_o(supply_low_flag_o),
  .hot_warning_flag_o(hot_warning_flag_o), .overcurrent_flag_o(overcurrent_flag_o));
